/* File: core/bridge_defs.svh */
// Functional notes
// - Send Assert_INTx when the first mapped line of a wire activates, Deassert_INTx when its last active line releases.
// - Merge all secondary interrupt pins into four upstream virtual wires A to D.
// - Virtual wire index is pin index plus source device number, modulo four.
// - Initial flow control credits are advertised only once the link is up.
// - Posted credits: header 04h, data 20h.
// - Non-posted credits: header 04h, data 04h.
// - Completion credits: header 08h, data 20h.
// - Type 1 request with bus above primary, up to secondary, and device 0 to 5 becomes a Type 0 cycle.
// - Type 0 address: function in 10:8, register in 7:2, bits 1:0 zero.
// - Device number n drives only address bit 16+n high as IDSEL.
`ifndef BRIDGE_DEFS_SVH
`define BRIDGE_DEFS_SVH

// Interrupt merging
`define NUM_WIRES 4
`define PINS_PER_SLOT 4

// Initial flow control credit values
`define FC_PH 8'h04
`define FC_PD 12'h020
`define FC_NPH 8'h04
`define FC_NPD 12'h004
`define FC_CPLH 8'h08
`define FC_CPLD 12'h020
`define FC_HDR_W 8
`define FC_DATA_W 12

// Type 0 address phase layout
`define T0_IDSEL_MSB 31
`define T0_IDSEL_LSB 16
`define T0_RSVD_MSB 15
`define T0_RSVD_LSB 11
`define T0_FUNC_MSB 10
`define T0_FUNC_LSB 8
`define T0_REG_MSB 7
`define T0_REG_LSB 2
`define T0_TYPE_MSB 1
`define T0_TYPE_LSB 0
`define IDSEL_ONE 16'h0001
`define MAX_IDSEL_DEV 5'h05
`define MAX_SLOTS 6

// Secondary bus commands
`define CMD_CFG_RD 4'hA
`define CMD_CFG_WR 4'hB

`endif

/* File: core/bridge_pkg.sv */
package bridge_pkg;

  // Configuration translation states, Gray coded from idle to done; done back to idle flips both bits
  typedef enum logic [1:0] {
    CFG_IDLE = 2'b00,
    CFG_ISSUE = 2'b01,
    CFG_DONE = 2'b11
  } cfg_state_t;

endpackage

/* File: core/intx_vwire.sv */
`timescale 1ns/1ps
`default_nettype none
module intx_vwire (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic level,
  input wire logic grant,
  output logic pending,
  output logic reported
);

  typedef struct packed {
    logic reported;
  } vwire_state_t;

  vwire_state_t state_ff;
  vwire_state_t nxt_state;

  // Wire state as last told upstream; updated when its message is loaded
  always_comb
  begin
    nxt_state = state_ff;
    if (grant)
    begin
      nxt_state.reported = level;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // A difference between the merged level and the told level is an edge still owed
  assign pending = level != state_ff.reported;
  assign reported = state_ff.reported;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  report_follow_a: assert property (grant |=> reported == $past(level))
    else $error("told wire state does not follow the granted level");
  no_pending_idle_a: assert property (!pending && !grant |=> !pending || $changed(level))
    else $error("pending raised without a level change");

endmodule
`default_nettype wire

/* File: core/pcie_pci_bridge_intx_cfg_map.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bridge_defs.svh"
module pcie_pci_bridge_intx_cfg_map #(
  parameter int NUM_SLOTS = 5
) (
  input wire logic core_clk,
  input wire logic reset_n,
  // Secondary INTA#..INTD# per slot, slot s at bits 4s+3..4s, active low pins
  input wire logic [NUM_SLOTS*`PINS_PER_SLOT-1:0] intPin_n,
  // Upstream INTx message port
  output logic msgValid,
  input wire logic msgReady,
  output logic msgAssert,
  output logic [1:0] msgWire,
  // Link status and credit advertisement
  input wire logic linkUp,
  output logic fcValid,
  output logic fcAdvertise,
  output logic [`FC_HDR_W-1:0] fcPh,
  output logic [`FC_DATA_W-1:0] fcPd,
  output logic [`FC_HDR_W-1:0] fcNph,
  output logic [`FC_DATA_W-1:0] fcNpd,
  output logic [`FC_HDR_W-1:0] fcCplh,
  output logic [`FC_DATA_W-1:0] fcCpld,
  // Bus number window
  input wire logic [7:0] priBusNum,
  input wire logic [7:0] secBusNum,
  // Upstream Type 1 configuration request
  input wire logic cfgReqValid,
  output logic cfgReqReady,
  input wire logic cfgReqWrite,
  input wire logic [7:0] cfgReqBus,
  input wire logic [4:0] cfgReqDev,
  input wire logic [2:0] cfgReqFunc,
  input wire logic [5:0] cfgReqReg,
  output logic cfgReject,
  // Secondary Type 0 configuration cycle
  output logic cycValid,
  input wire logic cycReady,
  output logic [31:0] cycAddr,
  output logic [3:0] cycCmd,
  output logic cfgDone
);
  import bridge_pkg::*;

  localparam int PIN_W = NUM_SLOTS * `PINS_PER_SLOT;

  // Slot s carries device number s, and IDSEL only reaches device 5
  if (NUM_SLOTS < 1 || NUM_SLOTS > `MAX_SLOTS)
  begin : g_bad_slots
    $error("NUM_SLOTS must lie between 1 and 6");
  end

  typedef struct packed {
    logic [PIN_W-1:0] pinMeta;
    logic [PIN_W-1:0] pinSync;
    logic msgValid;
    logic msgAssert;
    logic [1:0] msgWire;
    logic fcValid;
    logic fcAdvertise;
    logic [`FC_HDR_W-1:0] fcPh;
    logic [`FC_DATA_W-1:0] fcPd;
    logic [`FC_HDR_W-1:0] fcNph;
    logic [`FC_DATA_W-1:0] fcNpd;
    logic [`FC_HDR_W-1:0] fcCplh;
    logic [`FC_DATA_W-1:0] fcCpld;
    cfg_state_t cfgState;
    logic [31:0] cycAddr;
    logic [3:0] cycCmd;
    logic cfgReject;
  } bridge_state_t;

  bridge_state_t state_ff;
  bridge_state_t nxt_state;

  logic [`NUM_WIRES-1:0] merged;
  logic [`NUM_WIRES-1:0] pending;
  logic [`NUM_WIRES-1:0] reported;
  logic [`NUM_WIRES-1:0] grant;
  logic msgSlot;
  logic busInRange;
  logic devHasIdsel;
  logic [15:0] idsel;

  // Virtual wire = OR of every pin whose rotated index lands on it
  always_comb
  begin
    merged = '0;
    for (int v = 0; v < `NUM_WIRES; v++)
    begin
      for (int s = 0; s < NUM_SLOTS; s++)
      begin
        for (int p = 0; p < `PINS_PER_SLOT; p++)
        begin
          if (((p + s) % `NUM_WIRES) == v)
          begin
            merged[v] = merged[v] | ~state_ff.pinSync[s*`PINS_PER_SLOT+p];
          end
        end
      end
    end
  end

  // One tracker per virtual wire remembers what upstream was last told
  for (genvar w = 0; w < `NUM_WIRES; w++)
  begin : g_wire
    intx_vwire u_wire (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .level(merged[w]),
      .grant(grant[w]),
      .pending(pending[w]),
      .reported(reported[w])
    );
  end

  // Message slot frees when empty or when upstream takes the held one
  assign msgSlot = !state_ff.msgValid || msgReady;

  // Request qualification; bus equal to the primary is the bridge itself
  assign busInRange = (cfgReqBus > priBusNum) && (cfgReqBus <= secBusNum);
  assign devHasIdsel = cfgReqDev <= `MAX_IDSEL_DEV;
  assign idsel = `IDSEL_ONE << cfgReqDev;

  // Next-state logic for the whole block
  always_comb
  begin
    logic found;
    found = 1'b0;
    nxt_state = state_ff;
    grant = '0;

    // Two-stage synchroniser on the interrupt pins
    nxt_state.pinMeta = intPin_n;
    nxt_state.pinSync = state_ff.pinMeta;

    // Lowest owed wire wins; fixed priority is fair enough for four slow levels
    if (msgSlot)
    begin
      nxt_state.msgValid = 1'b0;
      for (int v = 0; v < `NUM_WIRES; v++)
      begin
        if (!found && pending[v])
        begin
          found = 1'b1;
          grant[v] = 1'b1;
          nxt_state.msgValid = 1'b1;
          nxt_state.msgWire = 2'(v);
          nxt_state.msgAssert = merged[v];
        end
      end
    end

    // Credits are held at zero until the link is up
    nxt_state.fcValid = linkUp;
    nxt_state.fcAdvertise = linkUp && !state_ff.fcValid;
    nxt_state.fcPh = linkUp ? `FC_PH : '0;
    nxt_state.fcPd = linkUp ? `FC_PD : '0;
    nxt_state.fcNph = linkUp ? `FC_NPH : '0;
    nxt_state.fcNpd = linkUp ? `FC_NPD : '0;
    nxt_state.fcCplh = linkUp ? `FC_CPLH : '0;
    nxt_state.fcCpld = linkUp ? `FC_CPLD : '0;

    // Configuration translation
    nxt_state.cfgReject = 1'b0;
    case (state_ff.cfgState)
      CFG_IDLE:
      begin
        if (cfgReqValid)
        begin
          if (busInRange && devHasIdsel)
          begin
            nxt_state.cfgState = CFG_ISSUE;
            nxt_state.cycAddr = '0;
            nxt_state.cycAddr[`T0_IDSEL_MSB:`T0_IDSEL_LSB] = idsel;
            nxt_state.cycAddr[`T0_FUNC_MSB:`T0_FUNC_LSB] = cfgReqFunc;
            nxt_state.cycAddr[`T0_REG_MSB:`T0_REG_LSB] = cfgReqReg;
            nxt_state.cycCmd = cfgReqWrite ? `CMD_CFG_WR : `CMD_CFG_RD;
          end
          else
          begin
            // Out of window or no IDSEL line for it: refused, not forwarded
            nxt_state.cfgReject = 1'b1;
          end
        end
      end
      CFG_ISSUE:
      begin
        if (cycReady)
        begin
          nxt_state.cfgState = CFG_DONE;
        end
      end
      CFG_DONE:
      begin
        nxt_state.cfgState = CFG_IDLE;
      end
      default:
      begin
        nxt_state.cfgState = CFG_IDLE;
      end
    endcase
  end

  // All state except the wire trackers' told levels in one register
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      // Pins idle high, so the synchroniser resets released and no false edge follows reset
      state_ff <= '0;
      state_ff.pinMeta <= '1;
      state_ff.pinSync <= '1;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Outputs
  assign msgValid = state_ff.msgValid;
  assign msgAssert = state_ff.msgAssert;
  assign msgWire = state_ff.msgWire;
  assign fcValid = state_ff.fcValid;
  assign fcAdvertise = state_ff.fcAdvertise;
  assign fcPh = state_ff.fcPh;
  assign fcPd = state_ff.fcPd;
  assign fcNph = state_ff.fcNph;
  assign fcNpd = state_ff.fcNpd;
  assign fcCplh = state_ff.fcCplh;
  assign fcCpld = state_ff.fcCpld;
  assign cfgReqReady = state_ff.cfgState == CFG_IDLE;
  assign cycValid = state_ff.cfgState == CFG_ISSUE;
  assign cycAddr = state_ff.cycAddr;
  assign cycCmd = state_ff.cycCmd;
  assign cfgReject = state_ff.cfgReject;
  assign cfgDone = state_ff.cfgState == CFG_DONE;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  // Accepted request, the held cycle, and its acceptance on the secondary bus
  sequence cfgTake;
    cfgReqValid && cfgReqReady && busInRange && devHasIdsel;
  endsequence
  sequence cfgHeld;
    cycValid && !cycReady;
  endsequence
  sequence cycTaken;
    cycValid && cycReady;
  endsequence

  // Message offered upstream but not yet taken
  sequence msgHeld;
    msgValid && !msgReady;
  endsequence

  // Interrupt merging and message checks
  wire_settle_a: assert property (merged[0] && msgSlot |=> reported[0])
    else $error("active wire A was not told upstream when the slot was free");
  msg_hold_a: assert property (msgHeld |=> msgValid && $stable(msgAssert) && $stable(msgWire))
    else $error("message changed before upstream took it");
  quiet_pins_a: assert property (&state_ff.pinSync |-> merged == '0)
    else $error("virtual wire active with all pins released");
  if (NUM_SLOTS > 1)
  begin : g_rot_chk
    rotate_one_a: assert property (!state_ff.pinSync[`PINS_PER_SLOT] |-> merged[1])
      else $error("slot one INTA did not reach wire B");
  end
  if (NUM_SLOTS > 3)
  begin : g_rot3_chk
    rotate_three_a: assert property (!state_ff.pinSync[3*`PINS_PER_SLOT] |-> merged[3])
      else $error("slot three INTA did not reach wire D");
  end
  // A freshly loaded deassert must name a wire whose merged level had already dropped
  deassert_last_a: assert property ($past(msgSlot) && msgValid && !msgAssert
    |-> ($past(merged) & (4'h1 << msgWire)) == 4'h0)
    else $error("deassert sent while a source still active");

  // Credit advertisement checks
  fc_linkdown_a: assert property (!linkUp |=> !fcValid && fcPh == '0 && fcCpld == '0)
    else $error("credits shown without link");
  fc_pulse_a: assert property ($rose(fcValid) |-> fcAdvertise ##1 !fcAdvertise)
    else $error("credit advertisement pulse wrong");
  fc_posted_a: assert property (fcValid |-> fcPh == `FC_PH && fcPd == `FC_PD)
    else $error("posted credit values wrong");
  fc_nonposted_a: assert property (fcValid |-> fcNph == `FC_NPH && fcNpd == `FC_NPD)
    else $error("non-posted credit values wrong");
  fc_cpl_a: assert property (fcValid |-> fcCplh == `FC_CPLH && fcCpld == `FC_CPLD)
    else $error("completion credit values wrong");

  // Configuration translation checks
  cfg_issue_a: assert property (cfgTake |=> cycValid && !cfgReqReady)
    else $error("accepted request not issued as Type 0");
  cfg_hold_a: assert property (cfgHeld |=> cycValid && $stable(cycAddr) && $stable(cycCmd))
    else $error("Type 0 cycle changed before it was accepted");
  cfg_done_a: assert property (cycTaken |=> cfgDone && !cycValid)
    else $error("accepted cycle not closed");
  cfg_refuse_a: assert property (cfgReqValid && cfgReqReady && !(busInRange && devHasIdsel)
    |=> cfgReject && !cycValid)
    else $error("out of range request not refused");
  t0_layout_a: assert property (cfgTake |=> cycAddr[`T0_FUNC_MSB:`T0_FUNC_LSB] == $past(cfgReqFunc)
    && cycAddr[`T0_REG_MSB:`T0_REG_LSB] == $past(cfgReqReg) && cycAddr[`T0_TYPE_MSB:`T0_TYPE_LSB] == '0
    && cycAddr[`T0_RSVD_MSB:`T0_RSVD_LSB] == '0)
    else $error("Type 0 address fields wrong");
  idsel_hot_a: assert property (cfgTake |=> cycAddr[`T0_IDSEL_LSB + 16'($past(cfgReqDev))]
    && $onehot(cycAddr[`T0_IDSEL_MSB:`T0_IDSEL_LSB]))
    else $error("IDSEL not one-hot at the device bit");

endmodule
`default_nettype wire

/* File: verif/far_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic slow,
  output logic msgReady,
  output logic cycReady
);
  logic [1:0] phase_ff;
  // Slow mode grants one cycle in three, so every handshake must hold
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      phase_ff <= 2'h0;
    else
      phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
  end
  // Grants of the two sides fall in different phases
  assign msgReady = !slow || (phase_ff == 2'h0);
  assign cycReady = !slow || (phase_ff == 2'h1);
endmodule
`default_nettype wire

/* File: verif/pcie_pci_bridge_intx_cfg_map_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module pcie_pci_bridge_intx_cfg_map_tb;
  localparam int NS = 5;
  logic core_clk, reset_n, msgValid, msgReady, msgAssert, linkUp, fcValid, fcAdvertise, slow;
  logic cfgReqValid, cfgReqReady, cfgReqWrite, cfgReject, cycValid, cycReady, cfgDone, lastAssert;
  logic [NS*4-1:0] intPin_n;
  logic [1:0] msgWire, lastWire;
  logic [7:0] fcPh, fcNph, fcCplh, priBusNum, secBusNum, cfgReqBus;
  logic [11:0] fcPd, fcNpd, fcCpld;
  logic [4:0] cfgReqDev;
  logic [2:0] cfgReqFunc;
  logic [5:0] cfgReqReg;
  logic [31:0] cycAddr;
  logic [3:0] cycCmd;
  int numErrors = 0, nCompared = 0, nMsg = 0, cycles = 0;

  pcie_pci_bridge_intx_cfg_map #(.NUM_SLOTS(NS)) i_dut (.core_clk(core_clk), .reset_n(reset_n),
    .intPin_n(intPin_n), .msgValid(msgValid), .msgReady(msgReady), .msgAssert(msgAssert),
    .msgWire(msgWire), .linkUp(linkUp), .fcValid(fcValid), .fcAdvertise(fcAdvertise),
    .fcPh(fcPh), .fcPd(fcPd), .fcNph(fcNph), .fcNpd(fcNpd), .fcCplh(fcCplh), .fcCpld(fcCpld),
    .priBusNum(priBusNum), .secBusNum(secBusNum), .cfgReqValid(cfgReqValid),
    .cfgReqReady(cfgReqReady), .cfgReqWrite(cfgReqWrite), .cfgReqBus(cfgReqBus),
    .cfgReqDev(cfgReqDev), .cfgReqFunc(cfgReqFunc), .cfgReqReg(cfgReqReg), .cfgReject(cfgReject),
    .cycValid(cycValid), .cycReady(cycReady), .cycAddr(cycAddr), .cycCmd(cycCmd), .cfgDone(cfgDone));
  far_side_model i_far (.core_clk(core_clk), .reset_n(reset_n), .slow(slow), .msgReady(msgReady),
    .cycReady(cycReady));

  // Clock
  initial core_clk = 1'b0;
  always #50 core_clk = ~core_clk;

  // Message log and hang guard; a taken message is one seen with ready at an edge
  always @(posedge core_clk)
  begin
    cycles++;
    if (msgValid === 1'b1 && msgReady === 1'b1)
    begin
      nMsg++;
      lastAssert = msgAssert;
      lastWire = msgWire;
    end
    if (cycles == 5000)
    begin
      numErrors++;
      finishTest();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nCompared++;
    if (seen !== exp)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finishTest();
    $display("Compared %0d, mismatches %0d", nCompared, numErrors);
    if (numErrors == 0 && nCompared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic setPin(input int idx, input logic v);
    @(posedge core_clk);
    intPin_n[idx] <= v;
  endtask

  // Bounded wait for exactly one further message
  task automatic expectMsg(input logic a, input logic [1:0] w);
    int n0;
    int k;
    n0 = nMsg;
    k = 0;
    while (nMsg == n0 && k < 30)
    begin
      @(negedge core_clk);
      k++;
    end
    check("msgCount", nMsg, n0 + 1);
    check("msgAssert", lastAssert, a);
    check("msgWire", lastWire, w);
  endtask

  task automatic expectQuiet();
    int n0;
    n0 = nMsg;
    repeat (10) @(negedge core_clk);
    check("msgQuiet", nMsg, n0);
  endtask

  task automatic testCredits();
    repeat (3) @(negedge core_clk);
    check("fcValid down", fcValid, 1'b0);
    check("fcPh down", fcPh, 8'h00);
    @(posedge core_clk);
    linkUp <= 1'b1;
    @(negedge core_clk);
    check("fcValid early", fcValid, 1'b0);
    @(negedge core_clk);
    check("fcAdvertise", fcAdvertise, 1'b1);
    check("fcPh", fcPh, 8'h04);
    check("fcPd", fcPd, 12'h020);
    check("fcNph", fcNph, 8'h04);
    check("fcNpd", fcNpd, 12'h004);
    check("fcCplh", fcCplh, 8'h08);
    check("fcCpld", fcCpld, 12'h020);
    @(negedge core_clk);
    check("fcAdvertise end", {fcValid, fcAdvertise}, 2'h2);
  endtask

  // Every pin of every slot, with the upstream side stalling on odd pins
  task automatic testIntMap();
    for (int s = 0; s < NS; s++)
      for (int p = 0; p < 4; p++)
      begin
        slow <= p[0];
        setPin(4 * s + p, 1'b0);
        expectMsg(1'b1, 2'((p + s) % 4));
        setPin(4 * s + p, 1'b1);
        expectMsg(1'b0, 2'((p + s) % 4));
      end
  endtask

  // Two sources share wire A; two wires asserted in one edge queue up
  task automatic testIntOr();
    @(posedge core_clk);
    intPin_n[1:0] <= 2'b00;
    expectMsg(1'b1, 2'h0);
    expectMsg(1'b1, 2'h1);
    setPin(7, 1'b0);
    expectQuiet();
    setPin(0, 1'b1);
    expectQuiet();
    setPin(7, 1'b1);
    expectMsg(1'b0, 2'h0);
    setPin(1, 1'b1);
    expectMsg(1'b0, 2'h1);
  endtask

  task automatic cfgReq(input logic [7:0] bus, input logic [4:0] dev, input logic [2:0] fn,
    input logic [5:0] rg, input logic wr, input logic ok);
    int k;
    k = 0;
    @(posedge core_clk);
    cfgReqValid <= 1'b1;
    cfgReqBus <= bus;
    cfgReqDev <= dev;
    cfgReqFunc <= fn;
    cfgReqReg <= rg;
    cfgReqWrite <= wr;
    do
    begin
      @(negedge core_clk);
      k++;
    end
    while (cfgReqReady !== 1'b1 && k < 20);
    @(posedge core_clk);
    cfgReqValid <= 1'b0;
    @(negedge core_clk);
    check("cycValid", cycValid, ok);
    check("cfgReject", cfgReject, !ok);
    check("cfgReqReady", cfgReqReady, !ok);
    if (ok)
    begin
      check("cycAddr", cycAddr, {16'h0001 << dev, 5'h00, fn, rg, 2'h0});
      check("cycCmd", cycCmd, wr ? 4'hB : 4'hA);
      k = 0;
      while (cfgDone !== 1'b1 && k < 20)
      begin
        @(negedge core_clk);
        k++;
      end
      check("cfgDone", cfgDone, 1'b1);
    end
  endtask

  // Window is bus 2..3; edges of the window and devices past the last select
  task automatic testCfg();
    slow <= 1'b1;
    for (int d = 0; d < 6; d++)
      cfgReq(8'h02 + 8'(d % 2), 5'(d), 3'(d), 6'h3F - 6'(d), d[0], 1'b1);
    cfgReq(8'h01, 5'h00, 3'h0, 6'h00, 1'b0, 1'b0);
    cfgReq(8'h04, 5'h01, 3'h1, 6'h01, 1'b1, 1'b0);
    cfgReq(8'h02, 5'h06, 3'h0, 6'h02, 1'b0, 1'b0);
  endtask

  // Main sequence
  initial
  begin
    reset_n = 1'b0;
    intPin_n = '1;
    linkUp = 1'b0;
    slow = 1'b0;
    priBusNum = 8'h01;
    secBusNum = 8'h03;
    cfgReqValid = 1'b0;
    cfgReqWrite = 1'b0;
    cfgReqBus = 8'h00;
    cfgReqDev = 5'h00;
    cfgReqFunc = 3'h0;
    cfgReqReg = 6'h00;
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    testCredits();
    testIntMap();
    testIntOr();
    testCfg();
    finishTest();
  end
endmodule
`default_nettype wire
